// >>> common/tcc_pkg.sv
// Shared constants for the timer capture/compare channel block.
// Assumes a plain register port with byte addresses and 32-bit data words.
package tcc_pkg;

   // ==========================================================================
   // Sizes
   localparam int NUM_CH    = 4;
   localparam int NUM_COMPL = 3;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;

   // ==========================================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_GLOBAL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_DEADTIME = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_ENABLE   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQDMA   = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_EVGEN    = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_CHCFG0   = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_CCR0     = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_STRIDE   = 8'h04;

   // ==========================================================================
   // Field positions
   localparam int GL_SMODE_LSB = 0;
   localparam int GL_TSEL_LSB  = 4;
   localparam int GL_ALIGN_LSB = 8;
   localparam int GL_MOE_BIT   = 15;
   localparam int EN_STRIDE    = 4;
   localparam int EN_CC        = 0;
   localparam int EN_POL       = 1;
   localparam int EN_NC        = 2;
   localparam int EN_NPOL      = 3;
   localparam int IRQ_LSB      = 0;
   localparam int DMA_LSB      = 8;
   localparam int FLAG_EV_LSB  = 0;
   localparam int FLAG_OV_LSB  = 8;
   localparam int EVG_CH_LSB   = 0;
   localparam int EVG_UPD_BIT  = 4;
   localparam int CFG_DIR_LSB  = 0;
   localparam int CFG_DIV_LSB  = 2;
   localparam int CFG_FILT_LSB = 4;
   localparam int CFG_MODE_LSB = 8;
   localparam int CFG_PRE_BIT  = 11;

   // ==========================================================================
   // Encodings
   typedef enum logic [1:0] {
      DIR_OUTPUT = 2'h0,
      DIR_OWN    = 2'h1,
      DIR_PAIR   = 2'h2,
      DIR_TRIG   = 2'h3
   } tcc_dir_t;

   typedef enum logic [2:0] {
      MODE_FROZEN     = 3'h0,
      MODE_ACT_MATCH  = 3'h1,
      MODE_INACT_MATCH= 3'h2,
      MODE_TOGGLE     = 3'h3,
      MODE_FORCE_LOW  = 3'h4,
      MODE_FORCE_HIGH = 3'h5,
      MODE_PWM1       = 3'h6,
      MODE_PWM2       = 3'h7
   } tcc_mode_t;

   typedef enum logic [1:0] {
      ALIGN_EDGE   = 2'h0,
      ALIGN_C_DOWN = 2'h1,
      ALIGN_C_UP   = 2'h2,
      ALIGN_C_BOTH = 2'h3
   } tcc_align_t;

   localparam logic [2:0] SLAVE_RESET    = 3'h4;
   localparam logic [2:0] TRIG_EDGE_ANY  = 3'h4;
   localparam logic [2:0] TRIG_IN1_PATH1 = 3'h5;
   localparam logic [2:0] TRIG_IN2_PATH2 = 3'h6;
   localparam logic [3:0] FILT_OFF       = 4'h0;
   localparam logic [3:0] FILT_LEN_MIN   = 4'h2;
   localparam logic [7:0] ONE_HOT_BASE   = 8'h01;

endpackage : tcc_pkg

// >>> logic/tcc_channels.sv
// Four capture/compare channels of a 16-bit advanced timer, with filter,
// edge divider, compare output modes, PWM, and dead time and complementary pins on channels 0 to 2 only.
// Assumes the counter core supplies the count, its direction and update pulses.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module tcc_channels
   import tcc_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int DT_W  = 10
) (
   // Clock and reset
   input  wire logic                clk_sys,
   input  wire logic                reset,
   // Register port
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output      logic [DATA_W-1:0]   reg_rdata,
   // Counter core
   input  wire logic [CNT_W-1:0]    core_counter,
   input  wire logic                count_down,
   input  wire logic                update_event,
   output      logic                core_reset_req,
   output      logic                software_update,
   // Channel pins
   input  wire logic [NUM_CH-1:0]    chan_in,
   output      logic [NUM_CH-1:0]    main_output,
   output      logic [NUM_CH-1:0]    main_output_oe,
   output      logic [NUM_COMPL-1:0] complementary_output,
   output      logic [NUM_COMPL-1:0] complementary_output_oe,
   output      logic [NUM_CH-1:0]    output_reference,
   // Event requests
   output      logic [NUM_CH-1:0]    irq_req,
   output      logic [NUM_CH-1:0]    dma_req
);

   // ==========================================================================
   // Elaboration check
   if (CNT_W < 2 || CNT_W > 16 || DT_W < 1 || DT_W > 16) begin : g_bad_param
      $error("tcc_channels: CNT_W must be 2..16 and DT_W 1..16");
   end

   // ==========================================================================
   // State
   typedef struct packed {
      logic [2:0]                     slave_mode_select;
      logic [2:0]                     trigger_select;
      logic [1:0]                     alignment_select;
      logic                           main_output_enable;
      logic [DT_W-1:0]                dead_time;
      logic [NUM_CH-1:0]              chan_output_capture_enable;
      logic [NUM_CH-1:0]              chan_polarity;
      logic [NUM_CH-1:0]              compl_output_enable;
      logic [NUM_CH-1:0]              compl_polarity;
      logic [NUM_CH-1:0]              chan_irq_enable;
      logic [NUM_CH-1:0]              chan_dma_enable;
      logic [NUM_CH-1:0]              chan_event_flag;
      logic [NUM_CH-1:0]              chan_overcapture_flag;
      logic [NUM_CH-1:0][1:0]         chan_direction_select;
      logic [NUM_CH-1:0][1:0]         input_edge_divider;
      logic [NUM_CH-1:0][3:0]         input_filter_field;
      logic [NUM_CH-1:0][2:0]         output_mode_field;
      logic [NUM_CH-1:0]              compare_preload_enable;
      logic [NUM_CH-1:0][CNT_W-1:0]   value_pre;
      logic [NUM_CH-1:0][CNT_W-1:0]   value_act;
      logic [NUM_CH-1:0]              filt;
      logic [NUM_CH-1:0]              filt_prev;
      logic [NUM_CH-1:0][2:0]         smp_cnt;
      logic [NUM_CH-1:0][3:0]         stable_cnt;
      logic [NUM_CH-1:0][2:0]         div_cnt;
      logic [NUM_CH-1:0]              eq_prev;
      logic [NUM_CH-1:0]              oref;
      logic [NUM_CH-1:0]              oref_prev;
      logic [NUM_CH-1:0][DT_W-1:0]    dt_cnt;
      logic [NUM_CH-1:0]              m_raw;
      logic [NUM_CH-1:0]              n_raw;
      logic [NUM_CH-1:0]              pin_m;
      logic [NUM_CH-1:0]              pin_m_oe;
      logic [NUM_CH-1:0]              pin_n;
      logic [NUM_CH-1:0]              pin_n_oe;
      logic [NUM_CH-1:0]              irq_p;
      logic [NUM_CH-1:0]              dma_p;
      logic                           cnt_rst;
      logic                           sw_upd;
      logic [DATA_W-1:0]              rdata;
   } tcc_state_t;

   tcc_state_t s_q;
   tcc_state_t s_d;

   // ==========================================================================
   // Helpers
   // Byte address of a per-channel register
   function automatic logic [ADDR_W-1:0] chan_ofs(input logic [ADDR_W-1:0] base, input int idx);
      chan_ofs = ADDR_W'(int'(base) + idx * int'(OFS_STRIDE));
   endfunction : chan_ofs

   // Highest count of a 1/2/4/8 divider selected by a 2-bit code
   function automatic logic [2:0] div_max(input logic [1:0] code);
      div_max = 3'((ONE_HOT_BASE << code) - ONE_HOT_BASE);
   endfunction : div_max

   // Consecutive samples needed: 2, 4, 6 or 8
   function automatic logic [3:0] filt_len(input logic [3:0] f);
      filt_len = 4'({f[1:0], 1'b0}) + FILT_LEN_MIN;
   endfunction : filt_len

   // ==========================================================================
   // Next state
   always_comb begin
      logic [NUM_CH-1:0] rise;
      logic [NUM_CH-1:0] fall;
      logic [NUM_CH-1:0] swev;
      logic              upd;
      logic              trig;
      logic              is_in;
      logic              act_edge;
      logic              fire;
      logic              ev_set;
      logic              eq;
      logic              match;
      logic              pwm_hi;
      logic              both;
      logic              mval;
      logic              nval;
      int                src;
      rise   = s_q.filt & ~s_q.filt_prev;
      fall   = ~s_q.filt & s_q.filt_prev;
      swev   = '0;
      upd    = 1'b0;
      trig   = 1'b0;
      is_in  = 1'b0;
      act_edge = 1'b0;
      fire   = 1'b0;
      ev_set = 1'b0;
      eq     = 1'b0;
      match  = 1'b0;
      pwm_hi = 1'b0;
      both   = 1'b0;
      mval   = 1'b0;
      nval   = 1'b0;
      src    = 0;
      s_d         = s_q;
      s_d.irq_p   = '0;
      s_d.dma_p   = '0;
      s_d.cnt_rst = 1'b0;
      s_d.sw_upd  = 1'b0;
      s_d.rdata   = '0;
      s_d.filt_prev = s_q.filt;

      // Shared register writes
      if (reg_wr) begin
         case (reg_addr)
            OFS_GLOBAL: begin
               s_d.slave_mode_select  = reg_wdata[GL_SMODE_LSB +: 3];
               s_d.trigger_select     = reg_wdata[GL_TSEL_LSB +: 3];
               s_d.alignment_select   = reg_wdata[GL_ALIGN_LSB +: 2];
               s_d.main_output_enable = reg_wdata[GL_MOE_BIT];
            end
            OFS_DEADTIME: s_d.dead_time = reg_wdata[DT_W-1:0];
            OFS_IRQDMA: begin
               s_d.chan_irq_enable = reg_wdata[IRQ_LSB +: NUM_CH];
               s_d.chan_dma_enable = reg_wdata[DMA_LSB +: NUM_CH];
            end
            OFS_EVGEN: begin
               swev       = reg_wdata[EVG_CH_LSB +: NUM_CH];
               s_d.sw_upd = reg_wdata[EVG_UPD_BIT];
               upd        = reg_wdata[EVG_UPD_BIT];
            end
            default: ;
         endcase
      end
      upd = upd | update_event;

      // Reset-mode trigger; a capture on the same edge still sees the old count
      case (s_q.trigger_select)
         TRIG_EDGE_ANY:  trig = rise[0] | fall[0];
         TRIG_IN1_PATH1: trig = s_q.chan_polarity[0] ? fall[0] : rise[0];
         TRIG_IN2_PATH2: trig = s_q.chan_polarity[1] ? fall[1] : rise[1];
         default:        trig = 1'b0;
      endcase
      s_d.cnt_rst = (s_q.slave_mode_select == SLAVE_RESET) && trig;

      // Register read data, one cycle later
      if (reg_rd) begin
         case (reg_addr)
            OFS_GLOBAL: begin
               s_d.rdata[GL_SMODE_LSB +: 3] = s_q.slave_mode_select;
               s_d.rdata[GL_TSEL_LSB +: 3]  = s_q.trigger_select;
               s_d.rdata[GL_ALIGN_LSB +: 2] = s_q.alignment_select;
               s_d.rdata[GL_MOE_BIT]        = s_q.main_output_enable;
            end
            OFS_DEADTIME: s_d.rdata[DT_W-1:0] = s_q.dead_time;
            OFS_IRQDMA: begin
               s_d.rdata[IRQ_LSB +: NUM_CH] = s_q.chan_irq_enable;
               s_d.rdata[DMA_LSB +: NUM_CH] = s_q.chan_dma_enable;
            end
            OFS_FLAGS: begin
               s_d.rdata[FLAG_EV_LSB +: NUM_CH] = s_q.chan_event_flag;
               s_d.rdata[FLAG_OV_LSB +: NUM_CH] = s_q.chan_overcapture_flag;
            end
            default: ;
         endcase
      end

      for (int i = 0; i < NUM_CH; i++) begin
         // Enable and polarity bits
         if (reg_wr && reg_addr == OFS_ENABLE) begin
            s_d.chan_output_capture_enable[i] = reg_wdata[EN_STRIDE*i + EN_CC];
            s_d.chan_polarity[i]              = reg_wdata[EN_STRIDE*i + EN_POL];
            s_d.compl_output_enable[i]        = (i < NUM_COMPL) && reg_wdata[EN_STRIDE*i + EN_NC];
            s_d.compl_polarity[i]             = (i < NUM_COMPL) && reg_wdata[EN_STRIDE*i + EN_NPOL];
         end
         if (reg_rd && reg_addr == OFS_ENABLE) begin
            s_d.rdata[EN_STRIDE*i + EN_CC]   = s_q.chan_output_capture_enable[i];
            s_d.rdata[EN_STRIDE*i + EN_POL]  = s_q.chan_polarity[i];
            s_d.rdata[EN_STRIDE*i + EN_NC]   = s_q.compl_output_enable[i];
            s_d.rdata[EN_STRIDE*i + EN_NPOL] = s_q.compl_polarity[i];
         end

         // Channel configuration
         if (reg_wr && reg_addr == chan_ofs(OFS_CHCFG0, i)) begin
            s_d.chan_direction_select[i]  = reg_wdata[CFG_DIR_LSB +: 2];
            s_d.input_edge_divider[i]     = reg_wdata[CFG_DIV_LSB +: 2];
            s_d.input_filter_field[i]     = reg_wdata[CFG_FILT_LSB +: 4];
            s_d.output_mode_field[i]      = reg_wdata[CFG_MODE_LSB +: 3];
            s_d.compare_preload_enable[i] = reg_wdata[CFG_PRE_BIT];
         end
         if (reg_rd && reg_addr == chan_ofs(OFS_CHCFG0, i)) begin
            s_d.rdata[CFG_DIR_LSB +: 2]  = s_q.chan_direction_select[i];
            s_d.rdata[CFG_DIV_LSB +: 2]  = s_q.input_edge_divider[i];
            s_d.rdata[CFG_FILT_LSB +: 4] = s_q.input_filter_field[i];
            s_d.rdata[CFG_MODE_LSB +: 3] = s_q.output_mode_field[i];
            s_d.rdata[CFG_PRE_BIT]       = s_q.compare_preload_enable[i];
         end

         // Digital filter: level moves only after enough equal samples
         if (s_q.input_filter_field[i] == FILT_OFF) begin
            s_d.filt[i]       = chan_in[i];
            s_d.smp_cnt[i]    = '0;
            s_d.stable_cnt[i] = '0;
         end else if (s_q.smp_cnt[i] >= div_max(s_q.input_filter_field[i][3:2])) begin
            s_d.smp_cnt[i] = '0;
            if (chan_in[i] != s_q.filt[i]) begin
               if (s_q.stable_cnt[i] + 4'h1 >= filt_len(s_q.input_filter_field[i])) begin
                  s_d.filt[i]       = chan_in[i];
                  s_d.stable_cnt[i] = '0;
               end else begin
                  s_d.stable_cnt[i] = s_q.stable_cnt[i] + 4'h1;
               end
            end else begin
               s_d.stable_cnt[i] = '0;
            end
         end else begin
            s_d.smp_cnt[i] = s_q.smp_cnt[i] + 3'h1;
         end

         // Input routing and active edge
         is_in = s_q.chan_direction_select[i] != DIR_OUTPUT;
         src   = (s_q.chan_direction_select[i] == DIR_PAIR) ? (i ^ 1) : i;
         act_edge = (s_q.chan_direction_select[i] == DIR_OWN || s_q.chan_direction_select[i] == DIR_PAIR)
                    && (s_q.chan_polarity[i] ? fall[src] : rise[src]);

         // Edge divider; restarts whenever capture is not armed
         fire = 1'b0;
         if (!is_in || !s_q.chan_output_capture_enable[i]) begin
            s_d.div_cnt[i] = '0;
         end else if (act_edge) begin
            if (s_q.div_cnt[i] >= div_max(s_q.input_edge_divider[i])) begin
               s_d.div_cnt[i] = '0;
               fire = 1'b1;
            end else begin
               s_d.div_cnt[i] = s_q.div_cnt[i] + 3'h1;
            end
         end

         // Compare value writes and preload transfer
         if (reg_wr && reg_addr == chan_ofs(OFS_CCR0, i)) begin
            s_d.value_pre[i] = reg_wdata[CNT_W-1:0];
            if (!s_q.compare_preload_enable[i]) begin
               s_d.value_act[i] = reg_wdata[CNT_W-1:0];
            end
         end
         if (upd && s_q.compare_preload_enable[i] && !is_in) begin
            s_d.value_act[i] = s_q.value_pre[i];
         end

         // Capture or compare event
         eq = core_counter == s_q.value_act[i];
         s_d.eq_prev[i] = eq;
         match = eq && !s_q.eq_prev[i];
         ev_set = 1'b0;
         if (is_in) begin
            if ((fire || swev[i]) && s_q.chan_output_capture_enable[i]) begin
               s_d.value_pre[i] = core_counter;
               s_d.value_act[i] = core_counter;
               ev_set = 1'b1;
            end
         end else begin
            case (s_q.alignment_select)
               ALIGN_C_DOWN: ev_set = match && count_down;
               ALIGN_C_UP:   ev_set = match && !count_down;
               default:      ev_set = match;
            endcase
            ev_set = ev_set || swev[i];
         end

         // Flags: clears first so a same-cycle set wins
         if (reg_wr && reg_addr == OFS_FLAGS) begin
            if (reg_wdata[FLAG_EV_LSB + i]) s_d.chan_event_flag[i] = 1'b0;
            if (reg_wdata[FLAG_OV_LSB + i]) s_d.chan_overcapture_flag[i] = 1'b0;
         end
         if (reg_rd && reg_addr == chan_ofs(OFS_CCR0, i)) begin
            s_d.rdata[CNT_W-1:0]   = s_q.value_pre[i];
            s_d.chan_event_flag[i] = 1'b0;
         end
         if (ev_set) begin
            if (is_in && s_q.chan_event_flag[i]) begin
               s_d.chan_overcapture_flag[i] = 1'b1;
            end
            s_d.chan_event_flag[i] = 1'b1;
            s_d.irq_p[i] = s_q.chan_irq_enable[i];
            s_d.dma_p[i] = s_q.chan_dma_enable[i];
         end

         // Reference level
         pwm_hi = core_counter > s_q.value_act[i];
         if (is_in) begin
            s_d.oref[i] = 1'b0;
         end else begin
            case (s_q.output_mode_field[i])
               MODE_ACT_MATCH:   s_d.oref[i] = match ? 1'b1 : s_q.oref[i];
               MODE_INACT_MATCH: s_d.oref[i] = match ? 1'b0 : s_q.oref[i];
               MODE_TOGGLE:      s_d.oref[i] = match ^ s_q.oref[i];
               MODE_FORCE_LOW:   s_d.oref[i] = 1'b0;
               MODE_FORCE_HIGH:  s_d.oref[i] = 1'b1;
               MODE_PWM1:        s_d.oref[i] = pwm_hi;
               MODE_PWM2:        s_d.oref[i] = !pwm_hi;
               default:          s_d.oref[i] = s_q.oref[i];
            endcase
         end

         // Dead time: every reference change restarts the delay
         s_d.oref_prev[i] = s_q.oref[i];
         if (s_q.oref[i] != s_q.oref_prev[i]) begin
            s_d.dt_cnt[i] = s_q.dead_time;
            s_d.m_raw[i]  = 1'b0;
            s_d.n_raw[i]  = 1'b0;
         end else if (s_q.dt_cnt[i] != '0) begin
            s_d.dt_cnt[i] = s_q.dt_cnt[i] - DT_W'(1);
         end else begin
            s_d.m_raw[i] = s_q.oref[i];
            s_d.n_raw[i] = !s_q.oref[i];
         end

         // Pins: delay only applies when both outputs of a pair run
         both = s_q.chan_output_capture_enable[i] && s_q.compl_output_enable[i];
         mval = both ? s_q.m_raw[i] : s_q.oref[i];
         nval = both ? s_q.n_raw[i] : !s_q.oref[i];
         s_d.pin_m_oe[i] = s_q.main_output_enable && s_q.chan_output_capture_enable[i] && !is_in;
         s_d.pin_n_oe[i] = s_q.main_output_enable && s_q.compl_output_enable[i] && !is_in;
         s_d.pin_m[i] = s_d.pin_m_oe[i] && (mval ^ s_q.chan_polarity[i]);
         s_d.pin_n[i] = s_d.pin_n_oe[i] && (nval ^ s_q.compl_polarity[i]);
      end
   end

   // ==========================================================================
   // State register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================================
   // Outputs, all straight from flip-flops
   assign reg_rdata               = s_q.rdata;
   assign core_reset_req          = s_q.cnt_rst;
   assign software_update         = s_q.sw_upd;
   assign main_output             = s_q.pin_m;
   assign main_output_oe          = s_q.pin_m_oe;
   assign complementary_output    = s_q.pin_n[NUM_COMPL-1:0];
   assign complementary_output_oe = s_q.pin_n_oe[NUM_COMPL-1:0];
   assign output_reference        = s_q.oref;
   assign irq_req                 = s_q.irq_p;
   assign dma_req                 = s_q.dma_p;

endmodule : tcc_channels

// >>> testbench/tcc_channels_assertions.sv
// Checker for channel 0 of the capture/compare block, bound to its top module.
// Assumes edge alignment and compare preload off throughout the run.
`timescale 1ns/1ns
module tcc_channels_assertions
   import tcc_pkg::*;
#(parameter int CNT_W = 16) (
   // Clock and reset
   input wire logic              clk_sys,
   input wire logic              reset,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   // Core and pins
   input wire logic [CNT_W-1:0]  core_counter,
   input wire logic              core_reset_req,
   input wire logic              software_update,
   input wire logic [NUM_CH-1:0] main_output,
   input wire logic [NUM_CH-1:0] main_output_oe,
   input wire logic [NUM_CH-1:0] output_reference,
   input wire logic [NUM_CH-1:0] irq_req
);
   // =====
   // Shadow copies of the controls, so outputs can be tied to their causes
   logic [15:0]      gl_q, cfg_q, ie_q;
   logic [CNT_W-1:0] cmp_q;
   always_ff @(posedge clk_sys)
      if (reset) {gl_q, cfg_q, ie_q, cmp_q} <= '0;
      else if (reg_wr) begin
         if (reg_addr == OFS_GLOBAL) gl_q <= reg_wdata[15:0];
         if (reg_addr == OFS_CHCFG0) cfg_q <= reg_wdata[15:0];
         if (reg_addr == OFS_IRQDMA) ie_q <= reg_wdata[15:0];
         if (reg_addr == OFS_CCR0) cmp_q <= reg_wdata[CNT_W-1:0];
      end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // First cycle of a match on a compare channel with its interrupt enabled
   sequence match_s;
      cfg_q[1:0] == 2'h0 && ie_q[IRQ_LSB] && core_counter == cmp_q && $past(core_counter) != cmp_q;
   endsequence
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0) else $error("read data out of slot");
   pin_off_a: assert property (!main_output_oe[0] |-> !main_output[0]) else $error("pin high undriven");
   oe_gate_a: assert property (main_output_oe[0] |-> $past(gl_q[GL_MOE_BIT])) else $error("oe without main");
   force_low_a: assert property (cfg_q[10:8] == MODE_FORCE_LOW |=> !output_reference[0]) else $error("not low");
   force_high_a: assert property (cfg_q[10:8] == MODE_FORCE_HIGH |=> output_reference[0]) else $error("not high");
   pwm_level_a: assert property (cfg_q[10:8] == MODE_PWM1 |=>
      output_reference[0] == ($past(core_counter) > $past(cmp_q))) else $error("pwm level wrong");
   match_irq_a: assert property (match_s |=> irq_req[0]) else $error("match without irq");
   irq_cause_a: assert property (irq_req[0] |-> $past(ie_q[IRQ_LSB])) else $error("irq not enabled");
   slave_rst_a: assert property (core_reset_req |-> $past(gl_q[2:0]) == SLAVE_RESET) else $error("bad reset");
   sw_update_a: assert property (reg_wr && reg_addr == OFS_EVGEN && reg_wdata[EVG_UPD_BIT] |=> software_update)
      else $error("no update pulse");
endmodule : tcc_channels_assertions
bind tcc_channels tcc_channels_assertions #(.CNT_W(CNT_W)) tcc_channels_assertions_inst (.clk_sys, .reset,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_counter, .core_reset_req, .software_update,
   .main_output, .main_output_oe, .output_reference, .irq_req);

// >>> testbench/tcc_core_model.sv
// Counter core model: up counter that wraps at a reload value.
// Assumes one count per clk_sys cycle; restarts on a slave reset request.
`timescale 1ns/1ns
module tcc_core_model #(parameter logic [15:0] RELOAD = 16'h00FF) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // Core side
   input  wire logic        core_reset_req,
   output      logic [15:0] core_counter,
   output      logic        count_down,
   output      logic        update_event
);
   // =====
   // Wrap or slave reset both restart from zero with an update pulse
   always_ff @(posedge clk_sys) begin
      update_event <= !reset && (core_reset_req || core_counter == RELOAD);
      if (reset || core_reset_req || core_counter == RELOAD) core_counter <= 16'h0000;
      else core_counter <= core_counter + 16'h0001;
   end
   assign count_down = 1'b0; // Edge alignment only, so period is RELOAD+1
endmodule : tcc_core_model

// >>> testbench/tcc_channels_bench.sv
// Bench for the capture/compare block: register tasks, pin pulses, counted events.
// Assumes the core model as counter; all channel pins follow one bench pin.
`timescale 1ns/1ns
module tcc_channels_bench
   import tcc_pkg::*;
;
   // =====
   logic        clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pin = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, q, period;
   logic [15:0] core_counter;
   logic        count_down, update_event, core_reset_req, software_update;
   logic [3:0]  main_output, main_output_oe, output_reference, irq_req, dma_req;
   logic [2:0]  complementary_output, complementary_output_oe;
   int          num_errors = 0, n_tests = 0, n_irq = 0, n_dma = 0, b0, b1;
   tcc_mode_t   modes[4] = '{MODE_TOGGLE, MODE_FORCE_LOW, MODE_FORCE_HIGH, MODE_PWM1};
   always #2 clk_sys = ~clk_sys;
   tcc_channels tcc_channels_inst (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .core_counter, .count_down, .update_event, .core_reset_req, .software_update, .chan_in({4{pin}}),
      .main_output, .main_output_oe, .complementary_output, .complementary_output_oe, .output_reference,
      .irq_req, .dma_req);
   tcc_core_model tcc_core_model_inst (.clk_sys, .reset, .core_reset_req, .core_counter, .count_down, .update_event);
   // Event pulse tallies; tests compare differences, never clear them
   always @(posedge clk_sys) begin
      n_irq <= n_irq + int'(irq_req[0]);
      n_dma <= n_dma + int'(dma_req[1]);
   end
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
      @(posedge clk_sys);
      {reg_wr, reg_rd} <= 2'b00;
      @(negedge clk_sys);
      q = reg_rdata;
   endtask : bus
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check($sformatf("reg %h", a), q, exp);
   endtask : rdchk
   task automatic pulses(input int n, input int hi, input int lo);
      repeat (n) begin
         @(posedge clk_sys) pin <= 1'b1;
         repeat (hi) @(posedge clk_sys);
         pin <= 1'b0;
         repeat (lo - 1) @(posedge clk_sys);
      end
      repeat (8) @(posedge clk_sys);
   endtask : pulses
   task automatic test_done;
      $display("Counts: %0d compares, %0d mismatches", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   // Watchdog: a hang counts as a mismatch
   initial begin
      #100000;
      num_errors++;
      test_done();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      rdchk(OFS_FLAGS, 32'hF); // All channels start as compares at count zero
      rdchk(8'h80, 32'h0); // Unmapped address reads zero
      $display("done: reset");
      bus(1, OFS_IRQDMA, 32'h201);
      bus(1, OFS_CHCFG0, 32'h1);
      bus(1, OFS_CHCFG0 + OFS_STRIDE, 32'h2);
      bus(1, OFS_ENABLE, 32'h31);
      bus(1, OFS_GLOBAL, 32'h54);
      {b0, b1} = {n_irq, n_dma};
      pulses(3, 20, 30);
      check("irq count", n_irq - b0, 3);
      check("dma count", n_dma - b1, 3);
      rdchk(OFS_FLAGS, 32'h30F);
      bus(0, OFS_CCR0, 32'h0);
      period = q;
      bus(0, OFS_CCR0 + OFS_STRIDE, 32'h0);
      check("period minus duty", period - q, 30);
      rdchk(OFS_FLAGS, 32'h30C);
      bus(1, OFS_FLAGS, 32'h300);
      rdchk(OFS_FLAGS, 32'hC);
      for (int dv = 0; dv < 4; dv++) begin
         bus(1, OFS_CHCFG0, 32'h1 | (dv << CFG_DIV_LSB));
         b0 = n_irq;
         pulses(8, 4, 4);
         check("divided irq count", n_irq - b0, 8 >> dv);
      end
      bus(1, OFS_ENABLE, 32'h30);
      b0 = n_irq;
      pulses(2, 4, 4);
      check("irq while disabled", n_irq - b0, 0);
      bus(1, OFS_FLAGS, 32'h303);
      bus(1, OFS_EVGEN, 32'h1);
      rdchk(OFS_FLAGS, 32'hC);
      bus(1, OFS_ENABLE, 32'h31);
      bus(1, OFS_EVGEN, 32'h1);
      rdchk(OFS_FLAGS, 32'hD);
      $display("done: capture");
      bus(1, OFS_GLOBAL, 32'h8000);
      bus(1, OFS_ENABLE, 32'h5);
      bus(1, OFS_CCR0, 32'h40);
      bus(1, OFS_EVGEN, 32'h10);
      foreach (modes[i]) begin
         bus(1, OFS_CHCFG0, 32'(modes[i]) << CFG_MODE_LSB);
         @(negedge clk_sys) b0 = n_irq;
         repeat (513) @(posedge clk_sys);
         check("match irq count", n_irq - b0, 2);
      end
      check("main pin enable", main_output_oe[0], 1'b1);
      check("compl pin enable", complementary_output_oe[0], 1'b1);
      $display("done: compare");
      test_done();
   end
endmodule : tcc_channels_bench
